/* rtl/fpl_pkg.sv */
// Shared constants and types for the front-panel LED indicator block
package fpl_pkg;

  // Clock rate and time base
  localparam int unsigned CLK_FREQ_MHZ   = 250;
  localparam int unsigned KHZ_PER_MHZ    = 1000;
  localparam int unsigned CLK_PER_MS     = CLK_FREQ_MHZ * KHZ_PER_MHZ;
  localparam int unsigned MS_PER_S       = 1000;

  // Status blink rates, in hertz, and their half periods in milliseconds
  localparam int unsigned STATUS_SLOW_HZ = 1;
  localparam int unsigned STATUS_FAST_HZ = 5;
  localparam int unsigned SLOW_HALF_MS   = MS_PER_S / (2 * STATUS_SLOW_HZ);
  localparam int unsigned FAST_HALF_MS   = MS_PER_S / (2 * STATUS_FAST_HZ);

  // Port-status button display time, in seconds and milliseconds
  localparam int unsigned BUTTON_SHOW_S  = 5;
  localparam int unsigned BUTTON_SHOW_MS = BUTTON_SHOW_S * MS_PER_S;

  // Visible length of one stretched traffic or collision flash, in milliseconds
  localparam int unsigned STRETCH_MS     = 50;

  // Default port count
  localparam int unsigned NUM_PORTS_DEF  = 8;

  // Width of millisecond counters (holds the button display time)
  localparam int unsigned MS_CNT_W       = 13;

  // Status indicator modes, one-hot
  typedef enum logic [3:0] {
    FPL_ST_RED   = 4'h1,
    FPL_ST_SOLID = 4'h2,
    FPL_ST_SLOW  = 4'h4,
    FPL_ST_FAST  = 4'h8
  } fpl_status_e;

endpackage : fpl_pkg

/* rtl/fpl_evt_if.sv */
// Carrier between the top and the event stretcher: events in, visible flashes out
`timescale 1ns/1ps
interface fpl_evt_if #(
  parameter int unsigned N = 8
);
  logic         tick;
  logic [N-1:0] act_evt;
  logic [N-1:0] col_evt;
  logic [N-1:0] act_vis;
  logic [N-1:0] col_vis;

  // Event source side
  modport src (
    output tick,
    output act_evt,
    output col_evt,
    input  act_vis,
    input  col_vis
  );

  // Stretcher side
  modport stretch (
    input  tick,
    input  act_evt,
    input  col_evt,
    output act_vis,
    output col_vis
  );
endinterface : fpl_evt_if

/* rtl/fpl_stretch.sv */
// Stretches short per-port traffic and collision events into visible flashes
`timescale 1ns/1ps
module fpl_stretch
  import fpl_pkg::*;
#(
  parameter int unsigned N         = NUM_PORTS_DEF,
  parameter int unsigned STRETCH_P = STRETCH_MS
) (
  // Clock and reset
  input wire logic    ref_clk,
  input wire logic    rst_n,
  // Events and flashes
  fpl_evt_if.stretch  bus
);

  localparam logic [MS_CNT_W-1:0] ON_LEN  = MS_CNT_W'(STRETCH_P);
  localparam logic [MS_CNT_W-1:0] CYC_LEN = MS_CNT_W'(2 * STRETCH_P);
  localparam logic [MS_CNT_W-1:0] ZERO    = {MS_CNT_W{1'b0}};
  localparam logic [MS_CNT_W-1:0] ONE     = {{(MS_CNT_W-1){1'b0}}, 1'b1};

  genvar gi;
  generate
    for (gi = 0; gi < 2 * N; gi++) begin : g_ch
      logic                evt;
      logic                pend_q;
      logic [MS_CNT_W-1:0] cnt_q;
      logic                start;

      // Channel gi < N is activity, the rest collision
      assign evt   = (gi < N) ? bus.act_evt[gi % N] : bus.col_evt[gi % N];
      assign start = (cnt_q == ZERO) && (pend_q || evt);

      // An event that starts an idle cycle is used at once; one seen during a cycle waits,
      // and a new event still wins over the start that consumes the pending one
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          pend_q <= 1'b0;
        end else begin
          pend_q <= (evt && !(start && !pend_q)) || (pend_q && !start);
        end
      end

      // One flash is ON_LEN lit, then ON_LEN dark, so steady traffic still blinks
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_q <= ZERO;
        end else if (start) begin
          cnt_q <= CYC_LEN;
        end else if (bus.tick && cnt_q != ZERO) begin
          cnt_q <= cnt_q - ONE;
        end
      end

      if (gi < N) begin : g_act
        assign bus.act_vis[gi] = (cnt_q > ON_LEN);
      end else begin : g_col
        assign bus.col_vis[gi - N] = (cnt_q > ON_LEN);
      end

      a_flash_starts: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start |=> (cnt_q == CYC_LEN) ##1 (cnt_q > ON_LEN))
        else $error("stretched flash did not start");
    end
  endgenerate

endmodule : fpl_stretch

/* rtl/fpl_top.sv */
// Front-panel indicator logic: port, status, temperature and backup-supply LEDs
`timescale 1ns/1ps
module fpl_top
  import fpl_pkg::*;
#(
  parameter int unsigned NUM_PORTS  = NUM_PORTS_DEF,
  parameter int unsigned TICK_CYC   = CLK_PER_MS,
  parameter int unsigned SLOW_HALF  = SLOW_HALF_MS,
  parameter int unsigned FAST_HALF  = FAST_HALF_MS,
  parameter int unsigned SHOW_MS    = BUTTON_SHOW_MS,
  parameter int unsigned STRETCH_P  = STRETCH_MS
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Per-port conditions from the switch core
  input  wire logic [NUM_PORTS-1:0] port_enable,
  input  wire logic [NUM_PORTS-1:0] port_hw_fault,
  input  wire logic [NUM_PORTS-1:0] port_present,
  input  wire logic [NUM_PORTS-1:0] port_link,
  input  wire logic [NUM_PORTS-1:0] port_activity,
  input  wire logic [NUM_PORTS-1:0] port_collision,
  input  wire logic [NUM_PORTS-1:0] port_full_duplex,
  input  wire logic [NUM_PORTS-1:0] port_speed_100,
  // System health
  input  wire logic                 boot_done,
  input  wire logic                 sys_resetting,
  input  wire logic                 sys_error,
  input  wire logic                 sw_updating,
  input  wire logic                 recovery_mode,
  input  wire logic                 maint_mode,
  // Temperature and supplies
  input  wire logic                 temp_above_normal,
  input  wire logic                 temp_too_high,
  input  wire logic                 backup_supply_present,
  input  wire logic                 main_supply_failed,
  // Front-panel button pin
  input  wire logic                 port_status_btn_n,
  // Port LEDs
  output logic      [NUM_PORTS-1:0] port_led_green_q,
  output logic      [NUM_PORTS-1:0] port_led_orange_q,
  // Status LED
  output logic                      status_led_green_q,
  output logic                      status_led_red_q,
  // Temperature LED and shutdown request
  output logic                      temp_led_green_q,
  output logic                      temp_led_orange_q,
  output logic                      temp_led_red_q,
  output logic                      shutdown_q,
  // Backup-supply LED
  output logic                      backup_supply_led_green_q,
  output logic                      backup_supply_led_orange_q
);

  localparam int unsigned           TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0]     TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [TICK_W-1:0]     TICK_ONE  = {{(TICK_W-1){1'b0}}, 1'b1};
  localparam logic [MS_CNT_W-1:0]   MS_ZERO   = {MS_CNT_W{1'b0}};
  localparam logic [MS_CNT_W-1:0]   MS_ONE    = {{(MS_CNT_W-1){1'b0}}, 1'b1};
  localparam logic [MS_CNT_W-1:0]   SLOW_LAST = MS_CNT_W'(SLOW_HALF - 1);
  localparam logic [MS_CNT_W-1:0]   FAST_LAST = MS_CNT_W'(FAST_HALF - 1);
  localparam logic [MS_CNT_W-1:0]   SHOW_LEN  = MS_CNT_W'(SHOW_MS);
  localparam logic [NUM_PORTS-1:0]  P_ZERO    = {NUM_PORTS{1'b0}};

  logic [TICK_W-1:0]   tick_cnt_q;
  logic                tick_q;
  logic                btn_meta_q;
  logic                btn_sync_q;
  logic                btn_prev_q;
  logic                btn_press;
  logic [MS_CNT_W-1:0] show_cnt_q;
  logic                show_q;
  logic [MS_CNT_W-1:0] slow_cnt_q;
  logic [MS_CNT_W-1:0] fast_cnt_q;
  logic                slow_ph_q;
  logic                fast_ph_q;
  fpl_status_e         st_q;
  fpl_status_e         st_d;
  logic                st_red_cond;
  logic                st_slow_cond;
  logic                st_green_d;
  logic [NUM_PORTS-1:0] dead;
  logic [NUM_PORTS-1:0] mgmt_off;
  logic [NUM_PORTS-1:0] coll_show;
  logic [NUM_PORTS-1:0] green_d;
  logic [NUM_PORTS-1:0] orange_d;

  fpl_evt_if #(.N(NUM_PORTS)) evt_bus ();

  // Millisecond enable from the system clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= {TICK_W{1'b0}};
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? {TICK_W{1'b0}} : tick_cnt_q + TICK_ONE;
    end
  end

  // Button pin synchroniser and press edge (pin is low while pressed)
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_meta_q <= 1'b1;
      btn_sync_q <= 1'b1;
      btn_prev_q <= 1'b1;
    end else begin
      btn_meta_q <= port_status_btn_n;
      btn_sync_q <= btn_meta_q;
      btn_prev_q <= btn_sync_q;
    end
  end

  assign btn_press = btn_prev_q && !btn_sync_q;

  // Speed and duplex display window; a new press restarts it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      show_cnt_q <= MS_ZERO;
    end else if (btn_press) begin
      show_cnt_q <= SHOW_LEN;
    end else if (tick_q && show_cnt_q != MS_ZERO) begin
      show_cnt_q <= show_cnt_q - MS_ONE;
    end
  end

  assign show_q = (show_cnt_q != MS_ZERO);

  // Status blink phases at the slow and fast rates
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt_q <= MS_ZERO;
      fast_cnt_q <= MS_ZERO;
      slow_ph_q  <= 1'b1;
      fast_ph_q  <= 1'b1;
    end else if (tick_q) begin
      slow_cnt_q <= (slow_cnt_q == SLOW_LAST) ? MS_ZERO : slow_cnt_q + MS_ONE;
      fast_cnt_q <= (fast_cnt_q == FAST_LAST) ? MS_ZERO : fast_cnt_q + MS_ONE;
      slow_ph_q  <= slow_ph_q ^ (slow_cnt_q == SLOW_LAST);
      fast_ph_q  <= fast_ph_q ^ (fast_cnt_q == FAST_LAST);
    end
  end

  // Status mode selection: red outranks blinking, maintenance outranks update
  assign st_red_cond  = !boot_done || sys_resetting || sys_error;
  assign st_slow_cond = sw_updating || recovery_mode;

  always_comb begin
    if (st_red_cond) begin
      st_d = FPL_ST_RED;
    end else if (maint_mode) begin
      st_d = FPL_ST_FAST;
    end else if (st_slow_cond) begin
      st_d = FPL_ST_SLOW;
    end else begin
      st_d = FPL_ST_SOLID;
    end
  end

  // Green drive for the status mode now held
  always_comb begin
    unique case (st_q)
      FPL_ST_RED:   st_green_d = 1'b0;
      FPL_ST_SOLID: st_green_d = 1'b1;
      FPL_ST_SLOW:  st_green_d = slow_ph_q;
      FPL_ST_FAST:  st_green_d = fast_ph_q;
      default:      st_green_d = 1'b0;
    endcase
  end

  // Status mode register and status LED
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q               <= FPL_ST_RED;
      status_led_red_q   <= 1'b1;
      status_led_green_q <= 1'b0;
    end else begin
      st_q               <= st_d;
      status_led_red_q   <= (st_q == FPL_ST_RED);
      status_led_green_q <= st_green_d;
    end
  end

  // Events into the stretcher
  assign evt_bus.tick    = tick_q;
  assign evt_bus.act_evt = port_activity;
  assign evt_bus.col_evt = port_collision & port_link & ~port_full_duplex;

  fpl_stretch #(
    .N         (NUM_PORTS),
    .STRETCH_P (STRETCH_P)
  ) u_stretch (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (evt_bus.stretch)
  );

  // Port classification, fault first, then disable, collision, activity, link
  assign dead      = port_hw_fault | ~port_present;
  assign mgmt_off  = ~dead & ~port_enable;
  assign coll_show = ~dead & port_enable & port_link & ~port_full_duplex & evt_bus.col_vis;

  genvar pi;
  generate
    for (pi = 0; pi < NUM_PORTS; pi++) begin : g_port
      logic green_sel;
      logic orange_sel;

      // Each port owns its own pair of drive bits, so no two processes write one variable
      always_comb begin
        if (show_q) begin
          green_sel  = port_speed_100[pi];
          orange_sel = port_full_duplex[pi];
        end else if (dead[pi]) begin
          green_sel  = 1'b1;
          orange_sel = 1'b1;
        end else if (mgmt_off[pi]) begin
          green_sel  = 1'b0;
          orange_sel = 1'b1;
        end else if (coll_show[pi] || (port_collision[pi] && port_link[pi] && !port_full_duplex[pi])) begin
          green_sel  = ~evt_bus.col_vis[pi];
          orange_sel = evt_bus.col_vis[pi]; // Orange is dark at rest, so it lights to blink
        end else if (port_link[pi]) begin
          green_sel  = ~evt_bus.act_vis[pi];
          orange_sel = 1'b0;
        end else begin
          green_sel  = 1'b0;
          orange_sel = 1'b0;
        end
      end

      assign green_d[pi]  = green_sel;
      assign orange_d[pi] = orange_sel;
    end
  endgenerate

  // Port LED registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_led_green_q  <= P_ZERO;
      port_led_orange_q <= P_ZERO;
    end else begin
      port_led_green_q  <= green_d;
      port_led_orange_q <= orange_d;
    end
  end

  // Temperature LED; shutdown request holds until reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_led_green_q  <= 1'b0;
      temp_led_orange_q <= 1'b0;
      temp_led_red_q    <= 1'b0;
      shutdown_q        <= 1'b0;
    end else begin
      temp_led_red_q    <= temp_too_high;
      temp_led_orange_q <= !temp_too_high && temp_above_normal;
      temp_led_green_q  <= !temp_too_high && !temp_above_normal;
      shutdown_q        <= shutdown_q || temp_too_high;
    end
  end

  // Backup-supply LED
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      backup_supply_led_green_q  <= 1'b0;
      backup_supply_led_orange_q <= 1'b0;
    end else begin
      backup_supply_led_orange_q <= backup_supply_present && main_supply_failed;
      backup_supply_led_green_q  <= backup_supply_present && !main_supply_failed;
    end
  end

  a_status_red_boot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!boot_done ##1 !boot_done) |=> status_led_red_q && !status_led_green_q)
    else $error("status not red during start-up");

  a_port_dark_nolink: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !show_q |=> ((port_led_green_q | port_led_orange_q)
                 & $past(~port_link & port_enable & ~dead)) == P_ZERO)
    else $error("unlinked enabled port not dark");

  a_mgmt_off_orange: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !show_q |=> ((port_led_orange_q & $past(mgmt_off)) == $past(mgmt_off))
                && ((port_led_green_q & $past(mgmt_off)) == P_ZERO))
    else $error("disabled port not solid orange");

  a_fault_both_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !show_q |=> ((port_led_green_q & port_led_orange_q & $past(dead)) == $past(dead)))
    else $error("faulted port not both solid");

  a_status_solid_green: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_d == FPL_ST_SOLID)[*2] |=> status_led_green_q && !status_led_red_q)
    else $error("normal status not solid green");

  a_slow_blink_tick: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(st_q, 2) == FPL_ST_SLOW && $past(st_q) == FPL_ST_SLOW && $changed(status_led_green_q))
      |-> $past(slow_cnt_q, 2) == SLOW_LAST)
    else $error("slow blink toggled off its period");

  a_fast_blink_tick: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(st_q, 2) == FPL_ST_FAST && $past(st_q) == FPL_ST_FAST && $changed(status_led_green_q))
      |-> $past(fast_cnt_q, 2) == FAST_LAST)
    else $error("fast blink toggled off its period");

  a_error_red: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sys_error |=> ##1 status_led_red_q)
    else $error("error did not light status red");

  a_temp_shutdown: assert property (@(posedge ref_clk) disable iff (!rst_n)
    temp_too_high |=> temp_led_red_q && shutdown_q && !temp_led_green_q)
    else $error("overheat not red with shutdown");

  a_backup_takeover: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (backup_supply_present && main_supply_failed) |=> backup_supply_led_orange_q && !backup_supply_led_green_q)
    else $error("backup takeover not orange");

  a_button_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
    btn_press |=> (show_cnt_q == SHOW_LEN) ##1 ((port_led_green_q == $past(port_speed_100))
                                              && (port_led_orange_q == $past(port_full_duplex))))
    else $error("button did not open speed display");

endmodule : fpl_top

/* test/fpl_panel_model.sv */
// Front-panel partner: the port-status push button with its pull-up
`timescale 1ns/1ps
module fpl_panel_model (
  // Clock
  input  wire logic ref_clk,
  // Button pin, low while pressed
  output logic      port_status_btn_n
);
  // Pull-up holds the pin high while the button is open
  initial begin
    port_status_btn_n = 1'b1;
  end

  // Press for a number of cycles, then let the pull-up return the pin high
  task automatic press(input int hold);
    @(negedge ref_clk);
    port_status_btn_n = 1'b0;
    repeat (hold) @(negedge ref_clk);
    port_status_btn_n = 1'b1;
  endtask : press
endmodule : fpl_panel_model

/* test/fpl_top_tb_top.sv */
// Self-checking bench for the front-panel indicator block
`timescale 1ns/1ps
module fpl_top_tb_top;
  import fpl_pkg::*;
  localparam int NP = 4;
  localparam int TK = 4;
  logic          ref_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [NP-1:0] en = '0, flt = '0, pres = '0, lnk = '0, act = '0, col = '0, fdx = '0, spd = '0;
  logic          boot = 0, sres = 0, serr = 0, upd = 0, rec = 0, mnt = 0;
  logic          t_hi = 0, t_max = 0, bk_p = 0, m_fail = 0;
  wire           btn_n;
  logic [NP-1:0] pg, po;
  logic          sg, sr, tg, to, tr, sd, bg, bo;
  int            mismatches = 0;
  int            num_checks = 0;

  // Clock at 250 MHz
  always #2 ref_clk = ~ref_clk;

  // Design with shortened counts
  fpl_top #(.NUM_PORTS(NP), .TICK_CYC(TK), .SLOW_HALF(5), .FAST_HALF(2), .SHOW_MS(20), .STRETCH_P(3)) fpl_top_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .port_enable(en), .port_hw_fault(flt), .port_present(pres),
    .port_link(lnk), .port_activity(act), .port_collision(col), .port_full_duplex(fdx),
    .port_speed_100(spd), .boot_done(boot), .sys_resetting(sres), .sys_error(serr),
    .sw_updating(upd), .recovery_mode(rec), .maint_mode(mnt), .temp_above_normal(t_hi),
    .temp_too_high(t_max), .backup_supply_present(bk_p), .main_supply_failed(m_fail),
    .port_status_btn_n(btn_n), .port_led_green_q(pg), .port_led_orange_q(po),
    .status_led_green_q(sg), .status_led_red_q(sr), .temp_led_green_q(tg), .temp_led_orange_q(to),
    .temp_led_red_q(tr), .shutdown_q(sd), .backup_supply_led_green_q(bg), .backup_supply_led_orange_q(bo));

  // Button partner
  fpl_panel_model fpl_panel_model_i (.ref_clk(ref_clk), .port_status_btn_n(btn_n));

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Compare a design value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Compare a measured count against bounds
  task automatic chk_cnt(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask : chk_cnt

  // Cycles between two toggles of the status green LED; the first two changes after mode entry are skipped
  task automatic half_period(output int n);
    logic p;
    int   w;
    w = 0;
    repeat (2) begin
      p = sg;
      while (sg === p && w < 400) begin
        cyc(1);
        w++;
      end
    end
    p = sg;
    n = 0;
    while (sg === p && n < 200) begin
      cyc(1);
      n++;
    end
  endtask : half_period

  // Count lit cycles of one port over a window
  task automatic count_lit(input int p, input int win, output int g_on, output int o_on);
    g_on = 0;
    o_on = 0;
    repeat (win) begin
      cyc(1);
      g_on += (pg[p] === 1'b1);
      o_on += (po[p] === 1'b1);
    end
  endtask : count_lit

  task automatic t_status;
    int n;
    chk({sg, sr}, 2'b01);
    boot = 1;
    cyc(2);
    chk({sg, sr}, 2'b10);
    sres = 1;
    cyc(2);
    chk({sg, sr}, 2'b01);
    sres = 0;
    serr = 1;
    cyc(2);
    chk({sg, sr}, 2'b01);
    serr = 0;
    upd = 1;
    half_period(n);
    chk_cnt(n, 5 * TK, 5 * TK);
    upd = 0;
    rec = 1;
    half_period(n);
    chk_cnt(n, 5 * TK, 5 * TK);
    mnt = 1;
    half_period(n);
    chk_cnt(n, 2 * TK, 2 * TK);
    {rec, mnt} = 2'b00;
    cyc(2);
    chk({sg, sr}, 2'b10);
    $display("test status done");
  endtask : t_status

  task automatic t_ports;
    {en, pres, flt, lnk} = {4'b1011, 4'b1111, 4'b1000, 4'b0010};
    cyc(1);
    chk({pg, po}, {4'b1010, 4'b1100});
    {en, pres, flt, lnk} = {4'b1010, 4'b1110, 4'b0100, 4'b1010};
    cyc(1);
    chk({pg, po}, {4'b1111, 4'b0101});
    $display("test ports done");
  endtask : t_ports

  task automatic t_flash;
    int g, o;
    {en, pres, flt, lnk, fdx} = {4'b1111, 4'b1111, 4'b0000, 4'b0001, 4'b0000};
    cyc(2);
    act[0] = 1;
    cyc(1);
    act[0] = 0;
    count_lit(0, 40, g, o);
    chk_cnt(40 - g, 2 * TK, 4 * TK);
    chk_cnt(o, 0, 0);
    col[0] = 1;
    cyc(1);
    col[0] = 0;
    count_lit(0, 40, g, o);
    chk_cnt(o, 1, 39);
    chk_cnt(g, 1, 39);
    fdx[0] = 1;
    cyc(30);
    col[0] = 1;
    cyc(1);
    col[0] = 0;
    count_lit(0, 40, g, o);
    chk_cnt(o, 0, 0);
    $display("test flash done");
  endtask : t_flash

  task automatic t_button;
    {lnk, spd, fdx} = {4'b0000, 4'b0101, 4'b0011};
    cyc(2);
    fpl_panel_model_i.press(3);
    cyc(3);
    chk({pg, po}, {4'b0101, 4'b0011});
    cyc(60);
    chk({pg, po}, {4'b0101, 4'b0011});
    cyc(40);
    chk({pg, po}, 8'h00);
    $display("test button done");
  endtask : t_button

  task automatic t_temp_supply;
    bit [1:0] bk [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
    logic [1:0] bx [4] = '{2'b00, 2'b10, 2'b01, 2'b00};
    for (int i = 0; i < 4; i++) begin
      {bk_p, m_fail} = bk[i];
      cyc(1);
      chk({bg, bo}, bx[i]);
    end
    {t_hi, t_max} = 2'b10;
    cyc(1);
    chk({tg, to, tr, sd}, 4'b0100);
    {t_hi, t_max} = 2'b01;
    cyc(1);
    chk({tg, to, tr, sd}, 4'b0011);
    {t_hi, t_max} = 2'b00;
    cyc(1);
    chk({tg, to, tr, sd}, 4'b1001);
    rst_n = 0;
    cyc(2);
    chk({sr, sg, sd, pg}, {3'b100, 4'b0000});
    rst_n = 1;
    cyc(3);
    chk(sd, 1'b0);
    $display("test temp_supply done");
  endtask : t_temp_supply

  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    #100000;
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    cyc(10);
    chk({sr, sg, pg, po}, {2'b10, 8'h00});
    rst_n = 1;
    cyc(3);
    t_status();
    t_ports();
    t_flash();
    t_button();
    t_temp_supply();
    close_out();
  end
endmodule : fpl_top_tb_top
